// ---- design/feature_control.v ----
// Purpose: feature-extension control register with paging pointers
// Assumes: all requests come from core logic on clk_i
// Notes:   every answer is registered and appears one cycle later
`timescale 1ns/1ps
`include "feature_ctrl_consts.vh"

module feature_control (
    // clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // control register moves
    input  wire        ctl_valid_i,
    input  wire        ctl_write_i,
    input  wire [3:0]  ctl_idx_i,
    input  wire [63:0] ctl_wdata_i,
    input  wire        mode64_i,
    output reg         ctl_done_o,
    output reg  [63:0] ctl_rdata_o,
    output reg         ctl_ud_o,
    output reg         ctl_gp_o,
    output reg         ctl_external_o,
    // page fault address capture
    input  wire        pf_valid_i,
    input  wire [63:0] pf_addr_i,
    // gated instruction checks
    input  wire        ins_valid_i,
    input  wire [3:0]  ins_kind_i,
    input  wire [1:0]  cpl_i,
    input  wire        v86_i,
    input  wire [2:0]  dr_idx_i,
    output wire        ins_done_o,
    output wire        ins_ud_o,
    output wire        ins_gp_o,
    output wire        ins_virt_o,
    output wire        ins_bitmap_o,
    output wire [2:0]  ins_dr_idx_o,
    // machine check events
    input  wire        mc_event_i,
    input  wire        mc_bank_en_i,
    input  wire        mc_uncorr_i,
    output reg         mc_record_o,
    output reg         mc_fault_o,
    // unmasked simd floating-point errors
    input  wire        simd_err_i,
    output reg         simd_xf_o,
    output reg         simd_ud_o,
    // paging state
    output wire [63:0] table_base_o,
    output wire [63:0] fault_addr_o,
    output wire        entry_wide_o,
    output wire [1:0]  page_size_sel_o,
    output wire        global_en_o,
    output reg         tlb_flush_o,
    output reg         tlb_keep_global_o,
    // feature levels
    output wire [63:0] feature_o,
    output wire        v86_ext_o,
    output wire        pvirq_o,
    output wire        io_break_en_o
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function is_reserved;
        input [3:0] idx;
        begin
            is_reserved = (idx == 4'd1) || (idx >= 4'd5 && idx <= 4'd7)
                          || (idx >= 4'd9);
        end
    endfunction

    function is_external;
        input [3:0] idx;
        begin
            is_external = (idx == `CTL_IDX_MODE) || (idx == `CTL_IDX_PRIO);
        end
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    reg  [63:0] feat_q;
    reg  [63:0] feat_d;
    reg  [63:0] base_q;
    reg  [63:0] base_d;
    reg  [63:0] faddr_q;
    reg  [63:0] faddr_d;
    reg  [63:0] rdata_d;
    reg         ud_d;
    reg         gp_d;
    reg         ext_d;
    reg         flush_d;
    wire        wr_ok;
    wire        rd_ok;

    assign wr_ok = ctl_valid_i && ctl_write_i;
    assign rd_ok = ctl_valid_i && !ctl_write_i;

    // ------------------------------------------------------------
    // move decode
    // ------------------------------------------------------------
    always @* begin
        feat_d  = feat_q;
        base_d  = base_q;
        faddr_d = faddr_q;
        rdata_d = 64'h0000_0000_0000_0000;
        ud_d    = 1'b0;
        gp_d    = 1'b0;
        ext_d   = 1'b0;
        flush_d = 1'b0;
        if (ctl_valid_i && is_reserved(ctl_idx_i)) begin
            ud_d = 1'b1;
        end else if (ctl_valid_i && is_external(ctl_idx_i)) begin
            ext_d = 1'b1;
        end else if (ctl_valid_i && ctl_idx_i == `CTL_IDX_FEAT) begin
            if (rd_ok) begin
                rdata_d = mode64_i ? feat_q
                                   : {32'h0000_0000, feat_q[31:0]};
            end else if (mode64_i && (ctl_wdata_i[63:32] != 32'h0000_0000)) begin
                gp_d = 1'b1;
            end else begin
                feat_d = ctl_wdata_i & `FEAT_WR_MASK;
            end
        end else if (ctl_valid_i && ctl_idx_i == `CTL_IDX_BASE) begin
            if (rd_ok) begin
                rdata_d = base_q;
            end else begin
                base_d  = mode64_i ? ctl_wdata_i
                                   : {32'h0000_0000, ctl_wdata_i[31:0]};
                flush_d = 1'b1;
            end
        end else if (ctl_valid_i && ctl_idx_i == `CTL_IDX_FADDR) begin
            if (rd_ok) begin
                rdata_d = mode64_i ? faddr_q
                                   : {32'h0000_0000, faddr_q[31:0]};
            end else begin
                faddr_d = mode64_i ? ctl_wdata_i
                                   : {32'h0000_0000, ctl_wdata_i[31:0]};
            end
        end
        // hardware capture wins over a software write
        if (pf_valid_i) begin
            faddr_d = pf_addr_i;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            feat_q            <= `FEAT_RESET;
            base_q            <= `BASE_RESET;
            faddr_q           <= `FADDR_RESET;
            ctl_done_o        <= 1'b0;
            ctl_rdata_o       <= 64'h0000_0000_0000_0000;
            ctl_ud_o          <= 1'b0;
            ctl_gp_o          <= 1'b0;
            ctl_external_o    <= 1'b0;
            tlb_flush_o       <= 1'b0;
            tlb_keep_global_o <= 1'b0;
        end else begin
            feat_q            <= feat_d;
            base_q            <= base_d;
            faddr_q           <= faddr_d;
            ctl_done_o        <= ctl_valid_i;
            ctl_rdata_o       <= rdata_d;
            ctl_ud_o          <= ud_d;
            ctl_gp_o          <= gp_d;
            ctl_external_o    <= ext_d;
            tlb_flush_o       <= flush_d;
            tlb_keep_global_o <= flush_d && feat_q[`FB_GLOBAL_PAGE];
        end
    end

    // ------------------------------------------------------------
    // machine check and simd error delivery
    // ------------------------------------------------------------
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mc_record_o <= 1'b0;
            mc_fault_o  <= 1'b0;
            simd_xf_o   <= 1'b0;
            simd_ud_o   <= 1'b0;
        end else begin
            mc_record_o <= mc_event_i && mc_bank_en_i;
            mc_fault_o  <= mc_event_i && mc_bank_en_i && mc_uncorr_i
                           && feat_q[`FB_MCHK_EN];
            simd_xf_o   <= simd_err_i && feat_q[`FB_SIMD_FAULT];
            simd_ud_o   <= simd_err_i && !feat_q[`FB_SIMD_FAULT];
        end
    end

    // ------------------------------------------------------------
    // instruction gate
    // ------------------------------------------------------------
    instr_gate u_gate (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .valid_i  (ins_valid_i),
        .kind_i   (ins_kind_i),
        .cpl_i    (cpl_i),
        .mode64_i (mode64_i),
        .v86_i    (v86_i),
        .dr_idx_i (dr_idx_i),
        .feat_i   (feat_q[18:0]),
        .done_o   (ins_done_o),
        .ud_o     (ins_ud_o),
        .gp_o     (ins_gp_o),
        .virt_o   (ins_virt_o),
        .bitmap_o (ins_bitmap_o),
        .dr_idx_o (ins_dr_idx_o)
    );

    // ------------------------------------------------------------
    // paging mode
    // ------------------------------------------------------------
    page_mode_decode u_page (
        .clk_i           (clk_i),
        .rst_i           (rst_i),
        .large_page_i    (feat_q[`FB_LARGE_PAGE]),
        .phys_ext_i      (feat_q[`FB_PHYS_EXT]),
        .global_page_i   (feat_q[`FB_GLOBAL_PAGE]),
        .entry_wide_o    (entry_wide_o),
        .page_size_sel_o (page_size_sel_o),
        .global_en_o     (global_en_o)
    );

    // ------------------------------------------------------------
    // levels
    // ------------------------------------------------------------
    assign feature_o     = feat_q;
    assign table_base_o  = base_q;
    assign fault_addr_o  = faddr_q;
    assign v86_ext_o     = feat_q[`FB_V86_EXT];
    assign pvirq_o       = feat_q[`FB_PVIRQ];
    assign io_break_en_o = feat_q[`FB_DEBUG_EXT];

endmodule

// ---- design/feature_ctrl_consts.vh ----
// Purpose: constants for the feature-control register bank
// Assumes: included by every design file of the bank
// Notes:   bit positions, indices, masks, reset values and codes
`ifndef FEATURE_CTRL_CONSTS_VH
`define FEATURE_CTRL_CONSTS_VH

// ------------------------------------------------------------
// feature register bit positions
// ------------------------------------------------------------
`define FB_V86_EXT        0
`define FB_PVIRQ          1
`define FB_TS_RESTRICT    2
`define FB_DEBUG_EXT      3
`define FB_LARGE_PAGE     4
`define FB_PHYS_EXT       5
`define FB_MCHK_EN        6
`define FB_GLOBAL_PAGE    7
`define FB_PERF_READ      8
`define FB_STATE_SAVE     9
`define FB_SIMD_FAULT     10
`define FB_SEG_BASE       16
`define FB_EXT_STATE      18

// ------------------------------------------------------------
// masks and reset values
// ------------------------------------------------------------
`define FEAT_WR_MASK      64'h0000_0000_0005_07ff
`define FEAT_RESET        64'h0000_0000_0000_0000
`define BASE_RESET        64'h0000_0000_0000_0000
`define FADDR_RESET       64'h0000_0000_0000_0000
`define SEG_BASE_IMPL     1'b1

// ------------------------------------------------------------
// control register indices
// ------------------------------------------------------------
`define CTL_IDX_MODE      4'h0
`define CTL_IDX_FADDR     4'h2
`define CTL_IDX_BASE      4'h3
`define CTL_IDX_FEAT      4'h4
`define CTL_IDX_PRIO      4'h8

// ------------------------------------------------------------
// instruction classes for the privilege gate
// ------------------------------------------------------------
`define K_TS_READ         4'h0
`define K_PERF_READ       4'h1
`define K_SIMD_LEGACY     4'h2
`define K_SEG_BASE        4'h3
`define K_XCTL_ACCESS     4'h4
`define K_XSAVE           4'h5
`define K_IRQ_FLAG        4'h6
`define K_SOFT_INT        4'h7
`define K_DEBUG_REG       4'h8
`define K_FX_SAVE         4'h9

// ------------------------------------------------------------
// page size selections
// ------------------------------------------------------------
`define PS_4K_ONLY        2'h0
`define PS_4K_4M          2'h1
`define PS_4K_2M          2'h2

`endif

// ---- design/page_mode_decode.v ----
// Purpose: registered page-size and entry-width decode
// Assumes: feature bits come from flops on the same clock
// Notes:   outputs lag the feature register by one cycle
`timescale 1ns/1ps
`include "feature_ctrl_consts.vh"

module page_mode_decode (
    // clock and reset
    input  wire       clk_i,
    input  wire       rst_i,
    // feature bits
    input  wire       large_page_i,
    input  wire       phys_ext_i,
    input  wire       global_page_i,
    // decoded paging mode
    output reg        entry_wide_o,
    output reg  [1:0] page_size_sel_o,
    output reg        global_en_o
);

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            entry_wide_o    <= 1'b0;
            page_size_sel_o <= `PS_4K_ONLY;
            global_en_o     <= 1'b0;
        end else begin
            entry_wide_o <= phys_ext_i;
            global_en_o  <= global_page_i;
            if (phys_ext_i) begin
                page_size_sel_o <= `PS_4K_2M;
            end else if (large_page_i) begin
                page_size_sel_o <= `PS_4K_4M;
            end else begin
                page_size_sel_o <= `PS_4K_ONLY;
            end
        end
    end

endmodule

// ---- design/instr_gate.v ----
// Purpose: fault and redirect decisions for feature-gated instructions
// Assumes: one request per valid cycle, answer one cycle later
// Notes:   privilege failures answer with a protection fault
`timescale 1ns/1ps
`include "feature_ctrl_consts.vh"

module instr_gate (
    // clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // request
    input  wire        valid_i,
    input  wire [3:0]  kind_i,
    input  wire [1:0]  cpl_i,
    input  wire        mode64_i,
    input  wire        v86_i,
    input  wire [2:0]  dr_idx_i,
    input  wire [18:0] feat_i,
    // answer
    output reg         done_o,
    output reg         ud_o,
    output reg         gp_o,
    output reg         virt_o,
    output reg         bitmap_o,
    output reg  [2:0]  dr_idx_o
);

    function priv_ok;
        input       restrict_b;
        input [1:0] cpl;
        begin
            priv_ok = !restrict_b || (cpl == 2'd0);
        end
    endfunction

    reg       ud_d;
    reg       gp_d;
    reg       virt_d;
    reg       bmp_d;
    reg [2:0] dr_d;

    // ------------------------------------------------------------
    // decision
    // ------------------------------------------------------------
    always @* begin
        ud_d   = 1'b0;
        gp_d   = 1'b0;
        virt_d = 1'b0;
        bmp_d  = 1'b0;
        dr_d   = dr_idx_i;
        case (kind_i)
            `K_TS_READ: gp_d = !priv_ok(feat_i[`FB_TS_RESTRICT], cpl_i);
            `K_PERF_READ: gp_d = !priv_ok(!feat_i[`FB_PERF_READ], cpl_i);
            `K_SIMD_LEGACY: ud_d = !feat_i[`FB_STATE_SAVE];
            `K_SEG_BASE: ud_d = !(feat_i[`FB_SEG_BASE] && `SEG_BASE_IMPL
                                  && mode64_i);
            `K_XCTL_ACCESS: ud_d = !feat_i[`FB_EXT_STATE];
            `K_XSAVE: ud_d = !feat_i[`FB_EXT_STATE];
            `K_FX_SAVE: ud_d = 1'b0;
            `K_IRQ_FLAG: begin
                virt_d = v86_i ? feat_i[`FB_V86_EXT]
                               : (feat_i[`FB_PVIRQ] && cpl_i == 2'd3);
            end
            `K_SOFT_INT: bmp_d = v86_i && feat_i[`FB_V86_EXT];
            `K_DEBUG_REG: begin
                if (dr_idx_i == 3'd4 || dr_idx_i == 3'd5) begin
                    if (feat_i[`FB_DEBUG_EXT]) begin
                        ud_d = 1'b1;
                    end else begin
                        dr_d = dr_idx_i + 3'd2;
                    end
                end
            end
            default: ud_d = 1'b1;
        endcase
    end

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            done_o   <= 1'b0;
            ud_o     <= 1'b0;
            gp_o     <= 1'b0;
            virt_o   <= 1'b0;
            bitmap_o <= 1'b0;
            dr_idx_o <= 3'd0;
        end else begin
            done_o   <= valid_i;
            ud_o     <= valid_i && ud_d;
            gp_o     <= valid_i && gp_d;
            virt_o   <= valid_i && virt_d;
            bitmap_o <= valid_i && bmp_d;
            dr_idx_o <= valid_i ? dr_d : 3'd0;
        end
    end

endmodule

// ---- dv/feature_control_chk.sv ----
// Purpose: concurrent checks on the feature-control bank ports
// Assumes: one clock domain, asynchronous reset active high
// Notes:   bound to every feature_control instance
`timescale 1ns/1ps
`include "feature_ctrl_consts.vh"

module feature_control_chk (
    // clock and reset
    input wire        clk_i,
    input wire        rst_i,
    // control moves
    input wire        ctl_valid_i,
    input wire        ctl_write_i,
    input wire [3:0]  ctl_idx_i,
    input wire [63:0] ctl_wdata_i,
    input wire        mode64_i,
    input wire        ctl_done_o,
    input wire        ctl_ud_o,
    input wire        ctl_gp_o,
    // instruction checks
    input wire        ins_valid_i,
    input wire [3:0]  ins_kind_i,
    input wire [1:0]  cpl_i,
    input wire [2:0]  dr_idx_i,
    input wire        ins_ud_o,
    input wire        ins_gp_o,
    input wire [2:0]  ins_dr_idx_o,
    // error events
    input wire        mc_event_i,
    input wire        mc_bank_en_i,
    input wire        mc_uncorr_i,
    input wire        mc_fault_o,
    input wire        simd_err_i,
    input wire        simd_xf_o,
    input wire        simd_ud_o,
    // paging and feature state
    input wire [1:0]  page_size_sel_o,
    input wire        tlb_flush_o,
    input wire        tlb_keep_global_o,
    input wire [63:0] feature_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ctl_answer_a: assert property (ctl_valid_i |=> ctl_done_o && ctl_ud_o ==
        !($past(ctl_idx_i) inside {`CTL_IDX_MODE, `CTL_IDX_FADDR, `CTL_IDX_BASE,
        `CTL_IDX_FEAT, `CTL_IDX_PRIO})) else $error("ctl answer");
    high_gp_a: assert property (ctl_valid_i && ctl_write_i && mode64_i &&
        ctl_idx_i == `CTL_IDX_FEAT && ctl_wdata_i[63:32] != 32'h0000_0000
        |=> ctl_gp_o && $stable(feature_o)) else $error("high bits");
    feat_write_a: assert property (ctl_valid_i && ctl_write_i &&
        ctl_idx_i == `CTL_IDX_FEAT && !(mode64_i && ctl_wdata_i[63:32] != 32'h0000_0000)
        |=> feature_o == ({32'h0000_0000, $past(ctl_wdata_i[31:0])} & `FEAT_WR_MASK))
        else $error("feature write");
    ts_priv_a: assert property (ins_valid_i && ins_kind_i == `K_TS_READ |=>
        ins_gp_o == ($past(feature_o[2]) && $past(cpl_i) != 2'h0)) else $error("ts gate");
    perf_priv_a: assert property (ins_valid_i && ins_kind_i == `K_PERF_READ |=>
        ins_gp_o == (!$past(feature_o[8]) && $past(cpl_i) != 2'h0)) else $error("perf gate");
    dbg_alias_a: assert property (ins_valid_i && ins_kind_i == `K_DEBUG_REG &&
        cpl_i == 2'h0 && dr_idx_i[2:1] == 2'b10 |=> ins_ud_o == $past(feature_o[3]) &&
        (ins_ud_o || ins_dr_idx_o == {2'b11, $past(dr_idx_i[0])})) else $error("debug alias");
    mc_fault_a: assert property (mc_event_i && mc_bank_en_i |=>
        mc_fault_o == ($past(mc_uncorr_i) && $past(feature_o[6]))) else $error("mc fault");
    simd_route_a: assert property (simd_err_i |=> simd_xf_o == $past(feature_o[10]) &&
        simd_ud_o != $past(feature_o[10])) else $error("simd route");
    page_sel_a: assert property (1'b1 |=> page_size_sel_o ==
        ($past(feature_o[5]) ? `PS_4K_2M : ($past(feature_o[4]) ? `PS_4K_4M : `PS_4K_ONLY)))
        else $error("page size");
    tlb_keep_a: assert property (ctl_valid_i && ctl_write_i && ctl_idx_i == `CTL_IDX_BASE
        |=> tlb_flush_o && tlb_keep_global_o == $past(feature_o[7])) else $error("tlb flush");
endmodule

bind feature_control feature_control_chk chk_u (
    .clk_i(clk_i), .rst_i(rst_i), .ctl_valid_i(ctl_valid_i), .ctl_write_i(ctl_write_i),
    .ctl_idx_i(ctl_idx_i), .ctl_wdata_i(ctl_wdata_i), .mode64_i(mode64_i),
    .ctl_done_o(ctl_done_o), .ctl_ud_o(ctl_ud_o), .ctl_gp_o(ctl_gp_o),
    .ins_valid_i(ins_valid_i), .ins_kind_i(ins_kind_i), .cpl_i(cpl_i), .dr_idx_i(dr_idx_i),
    .ins_ud_o(ins_ud_o), .ins_gp_o(ins_gp_o), .ins_dr_idx_o(ins_dr_idx_o),
    .mc_event_i(mc_event_i), .mc_bank_en_i(mc_bank_en_i), .mc_uncorr_i(mc_uncorr_i),
    .mc_fault_o(mc_fault_o), .simd_err_i(simd_err_i), .simd_xf_o(simd_xf_o),
    .simd_ud_o(simd_ud_o), .page_size_sel_o(page_size_sel_o), .tlb_flush_o(tlb_flush_o),
    .tlb_keep_global_o(tlb_keep_global_o), .feature_o(feature_o)
);

// ---- dv/tb_top.sv ----
// Purpose: self-checking bench for the feature-control bank
// Assumes: 200 MHz core clock, inputs driven 1 ns after each edge
// Notes:   one task per scenario, verdict printed by complete_run
`timescale 1ns/1ps
`include "feature_ctrl_consts.vh"

module tb_top;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        clk_i = 1'b0, rst_i = 1'b1, mode64_i = 1'b0, pf_valid_i = 1'b0;
    logic        ctl_valid_i = 1'b0, ctl_write_i = 1'b0, ins_valid_i = 1'b0, v86_i = 1'b0;
    logic        mc_event_i = 1'b0, mc_bank_en_i = 1'b0, mc_uncorr_i = 1'b0, simd_err_i = 1'b0;
    logic [3:0]  ctl_idx_i = 4'h0, ins_kind_i = 4'h0;
    logic [1:0]  cpl_i = 2'h0;
    logic [2:0]  dr_idx_i = 3'h0;
    logic [63:0] ctl_wdata_i = 64'h0, pf_addr_i = 64'h0;
    wire         ctl_done_o, ctl_ud_o, ctl_gp_o, ctl_external_o, ins_done_o, ins_ud_o;
    wire         ins_gp_o, ins_virt_o, ins_bitmap_o, mc_record_o, mc_fault_o, simd_xf_o;
    wire         simd_ud_o, entry_wide_o, global_en_o, tlb_flush_o, tlb_keep_global_o;
    wire         v86_ext_o, pvirq_o, io_break_en_o;
    wire [63:0]  ctl_rdata_o, table_base_o, fault_addr_o, feature_o;
    wire [2:0]   ins_dr_idx_o;
    wire [1:0]   page_size_sel_o;
    int          err_total = 0, tests_run = 0;

    always #2.5 clk_i = ~clk_i;

    feature_control dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .ctl_valid_i(ctl_valid_i), .ctl_write_i(ctl_write_i),
        .ctl_idx_i(ctl_idx_i), .ctl_wdata_i(ctl_wdata_i), .mode64_i(mode64_i),
        .ctl_done_o(ctl_done_o), .ctl_rdata_o(ctl_rdata_o), .ctl_ud_o(ctl_ud_o),
        .ctl_gp_o(ctl_gp_o), .ctl_external_o(ctl_external_o), .pf_valid_i(pf_valid_i),
        .pf_addr_i(pf_addr_i), .ins_valid_i(ins_valid_i), .ins_kind_i(ins_kind_i),
        .cpl_i(cpl_i), .v86_i(v86_i), .dr_idx_i(dr_idx_i), .ins_done_o(ins_done_o),
        .ins_ud_o(ins_ud_o), .ins_gp_o(ins_gp_o), .ins_virt_o(ins_virt_o),
        .ins_bitmap_o(ins_bitmap_o), .ins_dr_idx_o(ins_dr_idx_o), .mc_event_i(mc_event_i),
        .mc_bank_en_i(mc_bank_en_i), .mc_uncorr_i(mc_uncorr_i), .mc_record_o(mc_record_o),
        .mc_fault_o(mc_fault_o), .simd_err_i(simd_err_i), .simd_xf_o(simd_xf_o),
        .simd_ud_o(simd_ud_o), .table_base_o(table_base_o), .fault_addr_o(fault_addr_o),
        .entry_wide_o(entry_wide_o), .page_size_sel_o(page_size_sel_o),
        .global_en_o(global_en_o), .tlb_flush_o(tlb_flush_o),
        .tlb_keep_global_o(tlb_keep_global_o), .feature_o(feature_o), .v86_ext_o(v86_ext_o),
        .pvirq_o(pvirq_o), .io_break_en_o(io_break_en_o)
    );

    // ------------------------------------------------------------
    // compares and request tasks
    // ------------------------------------------------------------
    task automatic chk_word(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_word({63'h0, got}, {63'h0, exp});
    endtask

    // answers looked at 1 ns after the edge
    task automatic ctl_op(input logic wr, input logic [3:0] idx, input logic [63:0] d);
        @(posedge clk_i);
        #1;
        ctl_valid_i = 1'b1;
        ctl_write_i = wr;
        ctl_idx_i   = idx;
        ctl_wdata_i = d;
        @(posedge clk_i);
        #1;
        ctl_valid_i = 1'b0;
    endtask

    task automatic set_feat(input logic [63:0] v);
        ctl_op(1'b1, `CTL_IDX_FEAT, v);
    endtask

    task automatic ins_op(input logic [3:0] k, input logic [1:0] c, input logic v,
                          input logic [2:0] dr);
        @(posedge clk_i);
        #1;
        ins_valid_i = 1'b1;
        ins_kind_i  = k;
        cpl_i       = c;
        v86_i       = v;
        dr_idx_i    = dr;
        @(posedge clk_i);
        #1;
        ins_valid_i = 1'b0;
    endtask

    task automatic ins_ud(input logic [3:0] k, input logic [1:0] c, input logic exp);
        ins_op(k, c, 1'b0, 3'h0);
        chk_bit(ins_ud_o, exp);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset_rw;
        chk_word(feature_o, 64'h0);
        mode64_i = 1'b1;
        set_feat(64'h0000_0000_ffff_ffff);
        chk_word(feature_o, `FEAT_WR_MASK);
        set_feat(64'h8000_0000_0000_0001);
        chk_bit(ctl_gp_o, 1'b1);
        chk_word(feature_o, `FEAT_WR_MASK);
        mode64_i = 1'b0;
        set_feat(64'hffff_ffff_0000_0012);
        chk_bit(ctl_gp_o, 1'b0);
        ctl_op(1'b0, `CTL_IDX_FEAT, 64'h0);
        chk_word(ctl_rdata_o, 64'h0000_0000_0000_0012);
    endtask

    task automatic t_base;
        mode64_i = 1'b1;
        for (int g = 1; g >= 0; g--) begin
            set_feat({56'h0, g[0], 7'h0});
            ctl_op(1'b1, `CTL_IDX_BASE, 64'h1234_5678_9abc_d000);
            chk_bit(tlb_flush_o, 1'b1);
            chk_bit(tlb_keep_global_o, g[0]);
            chk_bit(global_en_o, g[0]);
        end
        chk_word(table_base_o, 64'h1234_5678_9abc_d000);
        mode64_i = 1'b0;
        ctl_op(1'b0, `CTL_IDX_BASE, 64'h0);
        chk_word(ctl_rdata_o, 64'h1234_5678_9abc_d000);
    endtask

    task automatic t_reserved;
        mode64_i = 1'b1;
        for (int i = 0; i < 16; i++) begin
            ctl_op(1'b0, i[3:0], 64'h0);
            chk_bit(ctl_ud_o, !(i inside {0, 2, 3, 4, 8}));
            chk_bit(ctl_external_o, i == 0 || i == 8);
        end
    endtask

    task automatic t_privilege;
        for (int f = 0; f < 2; f++) begin
            set_feat(f ? 64'h0000_0000_0000_0104 : 64'h0);
            for (int c = 0; c < 4; c += 3) begin
                ins_op(`K_TS_READ, c[1:0], 1'b0, 3'h0);
                chk_bit(ins_gp_o, f == 1 && c != 0);
                ins_op(`K_PERF_READ, c[1:0], 1'b0, 3'h0);
                chk_bit(ins_gp_o, f == 0 && c != 0);
            end
        end
    endtask

    task automatic t_debug;
        set_feat(64'h0);
        chk_bit(io_break_en_o, 1'b0);
        for (int d = 4; d < 6; d++) begin
            ins_op(`K_DEBUG_REG, 2'h0, 1'b0, d[2:0]);
            chk_word({61'h0, ins_dr_idx_o}, d + 2);
        end
        set_feat(64'h0000_0000_0000_0008);
        chk_bit(io_break_en_o, 1'b1);
        ins_op(`K_DEBUG_REG, 2'h0, 1'b0, 3'h5);
        chk_bit(ins_ud_o, 1'b1);
    endtask

    task automatic t_paging;
        for (int i = 0; i < 4; i++) begin
            set_feat({58'h0, i[1:0], 4'h0});
            @(posedge clk_i);
            #1;
            chk_word({62'h0, page_size_sel_o}, i[1] ? 64'h2 : {63'h0, i[0]});
            chk_bit(entry_wide_o, i[1]);
        end
    endtask

    task automatic t_errors;
        for (int i = 0; i < 8; i++) begin
            set_feat({53'h0, i[2], 3'h0, i[2], 6'h0});
            mc_event_i   = 1'b1;
            mc_bank_en_i = i[1];
            mc_uncorr_i  = i[0];
            simd_err_i   = 1'b1;
            @(posedge clk_i);
            #1;
            mc_event_i = 1'b0;
            simd_err_i = 1'b0;
            chk_bit(mc_record_o, i[1]);
            chk_bit(mc_fault_o, i[2] & i[1] & i[0]);
            chk_bit(simd_ud_o, !i[2]);
            chk_bit(simd_xf_o, i[2]);
        end
    endtask

    task automatic t_virtual;
        set_feat(64'h1);
        chk_bit(v86_ext_o, 1'b1);
        ins_op(`K_SOFT_INT, 2'h3, 1'b1, 3'h0);
        chk_bit(ins_bitmap_o, 1'b1);
        set_feat(64'h2);
        chk_bit(pvirq_o, 1'b1);
        ins_op(`K_IRQ_FLAG, 2'h3, 1'b0, 3'h0);
        chk_bit(ins_virt_o, 1'b1);
        ins_op(`K_SOFT_INT, 2'h3, 1'b1, 3'h0);
        chk_bit(ins_bitmap_o, 1'b0);
    endtask

    task automatic t_gated;
        mode64_i = 1'b1;
        set_feat(64'h0);
        ins_ud(`K_SIMD_LEGACY, 2'h3, 1'b1);
        ins_ud(`K_FX_SAVE, 2'h3, 1'b0);
        ins_ud(`K_XCTL_ACCESS, 2'h0, 1'b1);
        ins_ud(`K_SEG_BASE, 2'h3, 1'b1);
        set_feat(64'h200);
        ins_ud(`K_SIMD_LEGACY, 2'h3, 1'b0);
        set_feat(64'h0000_0000_0005_0200);
        ins_ud(`K_XCTL_ACCESS, 2'h0, 1'b0);
        ins_ud(`K_XSAVE, 2'h3, 1'b0);
        ins_ud(`K_SEG_BASE, 2'h3, 1'b0);
    endtask

    // ------------------------------------------------------------
    // run control
    // ------------------------------------------------------------
    task automatic complete_run;
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // tests take some 150 cycles; 4000 is a hang
    initial begin
        #20000;
        err_total++;
        complete_run();
    end

    initial begin
        repeat (3) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        t_reset_rw();
        t_base();
        t_reserved();
        t_privilege();
        t_debug();
        t_paging();
        t_errors();
        t_virtual();
        t_gated();
        complete_run();
    end
endmodule
